// ==== hw/csc_pkg.sv ====
// Constants for the cache-select and system-control register bank.
// Assumes one core clock; the encodings are the coprocessor register fields.
package csc_pkg;

  // ==========================================================================
  // Coprocessor register encodings {opcode1, primary, secondary, opcode2}
  // ==========================================================================
  localparam logic [2:0] CSC_SEL_OPC1   = 3'h2;
  localparam logic [3:0] CSC_SEL_CRN    = 4'h0;
  localparam logic [3:0] CSC_SEL_CRM    = 4'h0;
  localparam logic [2:0] CSC_SEL_OPC2   = 3'h0;
  localparam logic [2:0] CSC_ID_OPC1    = 3'h1;
  localparam logic [3:0] CSC_ID_CRN     = 4'h0;
  localparam logic [3:0] CSC_ID_CRM     = 4'h0;
  localparam logic [2:0] CSC_ID_OPC2    = 3'h0;
  localparam logic [2:0] CSC_CTL_OPC1   = 3'h0;
  localparam logic [3:0] CSC_CTL_CRN    = 4'h1;
  localparam logic [3:0] CSC_CTL_CRM    = 4'h0;
  localparam logic [2:0] CSC_CTL_OPC2   = 3'h0;

  // ==========================================================================
  // Cache size selection fields
  // ==========================================================================
  localparam int         CSC_SEL_INS_BIT = 0;
  localparam logic       CSC_SEL_INS_RST = 1'b0;

  // ==========================================================================
  // Cache size identification fields
  // ==========================================================================
  localparam int          CSC_ID_TOP_LSB   = 28;
  localparam logic [3:0]  CSC_ID_TOP_INSTR = 4'h2;
  localparam logic [3:0]  CSC_ID_TOP_DATA  = 4'h7;

  // ==========================================================================
  // System control fields
  // ==========================================================================
  localparam int          CSC_CTL_XS_BIT   = 30;
  localparam int          CSC_CTL_NMSK_BIT = 27;
  localparam int          CSC_CTL_XE_BIT   = 25;
  localparam int          CSC_CTL_LL_BIT   = 21;
  localparam int          CSC_CTL_DT_BIT   = 19;
  localparam int          CSC_CTL_BG_BIT   = 17;
  localparam logic        CSC_CTL_LL_RST   = 1'b0;
  localparam logic        CSC_CTL_DT_RST   = 1'b0;
  localparam logic        CSC_CTL_BG_RST   = 1'b0;
  localparam logic        CSC_CTL_STRAP_RST = 1'b0;
  // Bits 23:22, 18 and 16 read as one; all other fixed bits read as zero
  localparam logic [31:0] CSC_CTL_ONES     = 32'h00c5_0000;

  // ==========================================================================
  // Strap capture: edges after reset release before straps are loaded
  // ==========================================================================
  localparam logic [1:0]  CSC_STRAP_WAIT   = 2'h2;

  typedef enum logic [1:0] {CSC_REG_NONE, CSC_REG_SEL, CSC_REG_ID, CSC_REG_CTL} csc_reg_t;

  // Map a coprocessor access encoding onto a register
  function automatic csc_reg_t csc_decode(input logic [2:0] opc1, input logic [3:0] crn,
                                          input logic [3:0] crm, input logic [2:0] opc2);
    if ({opc1, crn, crm, opc2} == {CSC_SEL_OPC1, CSC_SEL_CRN, CSC_SEL_CRM, CSC_SEL_OPC2})
      return CSC_REG_SEL;
    if ({opc1, crn, crm, opc2} == {CSC_ID_OPC1, CSC_ID_CRN, CSC_ID_CRM, CSC_ID_OPC2})
      return CSC_REG_ID;
    if ({opc1, crn, crm, opc2} == {CSC_CTL_OPC1, CSC_CTL_CRN, CSC_CTL_CRM, CSC_CTL_OPC2})
      return CSC_REG_CTL;
    return CSC_REG_NONE;
  endfunction

endpackage

// ==== hw/csc_ctrl_if.sv ====
// Control bits handed from the register bank to the event unit.
// Assumes both ends sit on core_clk_i.
interface csc_ctrl_if;
  logic exc_endian;
  logic div_trap;
  logic bg_region;

  modport owner (output exc_endian, output div_trap, output bg_region);
  modport user  (input exc_endian, input div_trap, input bg_region);
endinterface

// ==== hw/csc_event_unit.sv ====
// Event side: exception endianness copy, divide-by-zero and background region.
// Assumes event inputs come from core logic on core_clk_i.
module csc_event_unit
  import csc_pkg::*;
(
  input  wire logic   core_clk_i,
  input  wire logic   reset_n_i,
  input  wire logic   ce_i,
  csc_ctrl_if.user    ctrl,
  input  wire logic   exception_entry_i,
  input  wire logic   div_valid_i,
  input  wire logic   div_by_zero_i,
  input  wire logic   mpu_enable_i,
  input  wire logic   mem_valid_i,
  input  wire logic   mem_unmapped_i,
  input  wire logic   mem_privileged_i,
  output logic        program_status_endian_o,
  output logic        div_undef_o,
  output logic        div_zero_result_o,
  output logic        background_fault_o,
  output logic        default_map_o
);

  logic next_endian;
  logic next_undef;
  logic next_zero_res;
  logic next_fault;
  logic next_default;

  // ==========================================================================
  // Next values
  // ==========================================================================
  always_comb
  begin
    next_endian   = program_status_endian_o;
    if (exception_entry_i)
      next_endian = ctrl.exc_endian;
    next_undef    = div_valid_i && div_by_zero_i && ctrl.div_trap;
    next_zero_res = div_valid_i && div_by_zero_i && !ctrl.div_trap;
    next_fault    = mem_valid_i && mpu_enable_i && mem_unmapped_i
                    && !(ctrl.bg_region && mem_privileged_i);
    next_default  = mem_valid_i && mpu_enable_i && mem_unmapped_i
                    && ctrl.bg_region && mem_privileged_i;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      program_status_endian_o <= 1'b0;
      div_undef_o             <= 1'b0;
      div_zero_result_o       <= 1'b0;
      background_fault_o      <= 1'b0;
      default_map_o           <= 1'b0;
    end
    else if (ce_i)
    begin
      program_status_endian_o <= next_endian;
      div_undef_o             <= next_undef;
      div_zero_result_o       <= next_zero_res;
      background_fault_o      <= next_fault;
      default_map_o           <= next_default;
    end
  end

endmodule // csc_event_unit

// ==== hw/csc_bank.sv ====
// Cache-select and system-control register bank, reached by coprocessor access.
// Assumes requests come from core logic on core_clk_i; strap pins are asynchronous.
//
// What this block does
// - Cache select accessible only when privileged
// - Cache level bits 3:1 read zero
// - Bit 0 selects instruction or data cache
// - Cache select read/write at opcode 2, c0
// - Identification top nibble 0010 instr, 0111 data
// - System control accessible only when privileged
// - Bit 30 exception state, reset from strap
// - Bit 27 read-only, reset from strap
// - Exception copies bit 25 into status endianness
// - Bit 21 low-latency select, resets zero
// - Bit 19 traps divide by zero
// - Bit 17 zero: unmapped access faults
// - Bit 17 one: privileged uses default map
module csc_bank
  import csc_pkg::*;
#(
  parameter logic        CACHES_PRESENT = 1'b1,
  parameter logic [27:0] ID_LOW_INSTR   = 28'h000_0000,
  parameter logic [27:0] ID_LOW_DATA    = 28'h000_0000
)
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // Coprocessor access
  input  wire logic        cp_req_i,
  input  wire logic        cp_write_i,
  input  wire logic        cp_privileged_i,
  input  wire logic [2:0]  cp_opc1_i,
  input  wire logic [3:0]  cp_crn_i,
  input  wire logic [3:0]  cp_crm_i,
  input  wire logic [2:0]  cp_opc2_i,
  input  wire logic [31:0] cp_wdata_i,
  output logic             cp_ack_o,
  output logic             cp_undef_o,
  output logic [31:0]      cp_rdata_o,
  // Strap pins
  input  wire logic        exception_state_reset_input_i,
  input  wire logic        nonmaskable_fast_irq_input_i,
  input  wire logic        endianness_reset_input_i,
  // Control outputs
  output logic             instruction_not_data_select_o,
  output logic             exception_state_select_o,
  output logic             nonmaskable_fast_irq_flag_o,
  output logic             exception_endianness_o,
  output logic             low_latency_select_o,
  output logic             divide_zero_trap_enable_o,
  output logic             background_region_enable_o,
  // Events
  input  wire logic        exception_entry_i,
  input  wire logic        div_valid_i,
  input  wire logic        div_by_zero_i,
  input  wire logic        mpu_enable_i,
  input  wire logic        mem_valid_i,
  input  wire logic        mem_unmapped_i,
  input  wire logic        mem_privileged_i,
  output logic             program_status_endian_o,
  output logic             div_undef_o,
  output logic             div_zero_result_o,
  output logic             background_fault_o,
  output logic             default_map_o
);

  // ==========================================================================
  // Strap synchroniser and capture after reset release
  // ==========================================================================
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic [1:0] strap_wait;
  logic [1:0] next_strap_wait;
  logic       strap_load;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      strap_wait <= 2'h0;
    end
    else if (ce_i)
    begin
      strap_meta <= {exception_state_reset_input_i, nonmaskable_fast_irq_input_i,
                     endianness_reset_input_i};
      strap_sync <= strap_meta;
      strap_wait <= next_strap_wait;
    end
  end

  always_comb
  begin
    next_strap_wait = strap_wait;
    strap_load      = 1'b0;
    if (strap_wait < CSC_STRAP_WAIT)
      next_strap_wait = strap_wait + 2'h1;
    else if (strap_wait == CSC_STRAP_WAIT)
    begin
      next_strap_wait = 2'h3;
      strap_load      = 1'b1;
    end
  end

  // ==========================================================================
  // Register access
  // ==========================================================================
  csc_reg_t    target;
  logic        access_ok;
  logic        sel_ins;
  logic        ctl_xs, ctl_nmsk, ctl_xe, ctl_ll, ctl_dt, ctl_bg;
  logic        next_sel_ins;
  logic        next_xs, next_nmsk, next_xe, next_ll, next_dt, next_bg;
  logic        next_ack;
  logic        next_undef;
  logic [31:0] next_rdata;
  logic [31:0] ctl_value;
  logic [31:0] id_value;

  always_comb
  begin
    target    = csc_decode(cp_opc1_i, cp_crn_i, cp_crm_i, cp_opc2_i);
    access_ok = cp_req_i && cp_privileged_i && (target != CSC_REG_NONE);
    // Fixed bits of system control
    ctl_value = CSC_CTL_ONES;
    ctl_value[CSC_CTL_XS_BIT]   = ctl_xs;
    ctl_value[CSC_CTL_NMSK_BIT] = ctl_nmsk;
    ctl_value[CSC_CTL_XE_BIT]   = ctl_xe;
    ctl_value[CSC_CTL_LL_BIT]   = ctl_ll;
    ctl_value[CSC_CTL_DT_BIT]   = ctl_dt;
    ctl_value[CSC_CTL_BG_BIT]   = ctl_bg;
    // Identification for the selected cache
    id_value = 32'h0;
    if (CACHES_PRESENT)
      id_value = sel_ins ? {CSC_ID_TOP_INSTR, ID_LOW_INSTR}
                         : {CSC_ID_TOP_DATA, ID_LOW_DATA};

    next_sel_ins = sel_ins;
    next_xs      = ctl_xs;
    next_nmsk    = ctl_nmsk;
    next_xe      = ctl_xe;
    next_ll      = ctl_ll;
    next_dt      = ctl_dt;
    next_bg      = ctl_bg;
    next_ack     = cp_req_i;
    next_undef   = cp_req_i && !access_ok;
    next_rdata   = 32'h0;

    if (access_ok && !cp_write_i)
    begin
      unique case (target)
        CSC_REG_SEL: next_rdata[CSC_SEL_INS_BIT] = sel_ins;
        CSC_REG_ID:  next_rdata = id_value;
        CSC_REG_CTL: next_rdata = ctl_value;
        default:     next_rdata = 32'h0;
      endcase
    end
    if (access_ok && cp_write_i)
    begin
      if (target == CSC_REG_SEL)
        next_sel_ins = cp_wdata_i[CSC_SEL_INS_BIT];
      if (target == CSC_REG_CTL)
      begin
        next_xs = cp_wdata_i[CSC_CTL_XS_BIT];
        next_xe = cp_wdata_i[CSC_CTL_XE_BIT];
        next_ll = cp_wdata_i[CSC_CTL_LL_BIT];
        next_dt = cp_wdata_i[CSC_CTL_DT_BIT];
        next_bg = cp_wdata_i[CSC_CTL_BG_BIT];
      end
      // Identification is read-only: a write there is refused
      if (target == CSC_REG_ID)
        next_undef = 1'b1;
    end
    if (strap_load)
    begin
      next_xs   = strap_sync[2];
      next_nmsk = strap_sync[1];
      next_xe   = strap_sync[0];
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sel_ins    <= CSC_SEL_INS_RST;
      ctl_xs     <= CSC_CTL_STRAP_RST;
      ctl_nmsk   <= CSC_CTL_STRAP_RST;
      ctl_xe     <= CSC_CTL_STRAP_RST;
      ctl_ll     <= CSC_CTL_LL_RST;
      ctl_dt     <= CSC_CTL_DT_RST;
      ctl_bg     <= CSC_CTL_BG_RST;
      cp_ack_o   <= 1'b0;
      cp_undef_o <= 1'b0;
      cp_rdata_o <= 32'h0;
    end
    else if (ce_i)
    begin
      sel_ins    <= next_sel_ins;
      ctl_xs     <= next_xs;
      ctl_nmsk   <= next_nmsk;
      ctl_xe     <= next_xe;
      ctl_ll     <= next_ll;
      ctl_dt     <= next_dt;
      ctl_bg     <= next_bg;
      cp_ack_o   <= next_ack;
      cp_undef_o <= next_undef;
      cp_rdata_o <= next_rdata;
    end
  end

  always_comb
  begin
    instruction_not_data_select_o = sel_ins;
    exception_state_select_o      = ctl_xs;
    nonmaskable_fast_irq_flag_o   = ctl_nmsk;
    exception_endianness_o        = ctl_xe;
    low_latency_select_o          = ctl_ll;
    divide_zero_trap_enable_o     = ctl_dt;
    background_region_enable_o    = ctl_bg;
  end

  // ==========================================================================
  // Event unit
  // ==========================================================================
  csc_ctrl_if ctrl_if ();

  always_comb
  begin
    ctrl_if.exc_endian = ctl_xe;
    ctrl_if.div_trap   = ctl_dt;
    ctrl_if.bg_region  = ctl_bg;
  end

  csc_event_unit u_events (
    .core_clk_i              (core_clk_i),
    .reset_n_i               (reset_n_i),
    .ce_i                    (ce_i),
    .ctrl                    (ctrl_if.user),
    .exception_entry_i       (exception_entry_i),
    .div_valid_i             (div_valid_i),
    .div_by_zero_i           (div_by_zero_i),
    .mpu_enable_i            (mpu_enable_i),
    .mem_valid_i             (mem_valid_i),
    .mem_unmapped_i          (mem_unmapped_i),
    .mem_privileged_i        (mem_privileged_i),
    .program_status_endian_o (program_status_endian_o),
    .div_undef_o             (div_undef_o),
    .div_zero_result_o       (div_zero_result_o),
    .background_fault_o      (background_fault_o),
    .default_map_o           (default_map_o)
  );

endmodule // csc_bank

// ==== bench/csc_bank_assertions.sv ====
// Concurrent checks on the ports of the cache-select and system-control bank.
// Assumes one core clock and an asynchronous active-low reset.
module csc_bank_chk
  import csc_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        ce_i,
  input wire logic        cp_req_i,
  input wire logic        cp_write_i,
  input wire logic        cp_privileged_i,
  input wire logic [2:0]  cp_opc1_i,
  input wire logic [3:0]  cp_crn_i,
  input wire logic [3:0]  cp_crm_i,
  input wire logic [2:0]  cp_opc2_i,
  input wire logic        cp_ack_o,
  input wire logic        cp_undef_o,
  input wire logic [31:0] cp_rdata_o,
  input wire logic        instruction_not_data_select_o,
  input wire logic        nonmaskable_fast_irq_flag_o,
  input wire logic        exception_endianness_o,
  input wire logic        divide_zero_trap_enable_o,
  input wire logic        background_region_enable_o,
  input wire logic        exception_entry_i,
  input wire logic        div_valid_i,
  input wire logic        div_by_zero_i,
  input wire logic        mpu_enable_i,
  input wire logic        mem_valid_i,
  input wire logic        mem_unmapped_i,
  input wire logic        mem_privileged_i,
  input wire logic        program_status_endian_o,
  input wire logic        div_undef_o,
  input wire logic        background_fault_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Access decode and checks
  // ==========================================================================
  logic [13:0] enc;
  logic        rd;
  assign enc = {cp_opc1_i, cp_crn_i, cp_crm_i, cp_opc2_i};
  assign rd  = cp_req_i && ce_i && cp_privileged_i && !cp_write_i;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  ack_one_a: assert property (cp_req_i && ce_i |=> cp_ack_o)
    else $error("request not acknowledged");
  unpriv_refuse_a: assert property (cp_req_i && ce_i && !cp_privileged_i
    |=> cp_undef_o && cp_rdata_o == 32'h0) else $error("unprivileged access not refused");
  sel_read_a: assert property (rd && enc == {CSC_SEL_OPC1, CSC_SEL_CRN, CSC_SEL_CRM, CSC_SEL_OPC2}
    |=> cp_rdata_o == {31'h0, $past(instruction_not_data_select_o)}) else $error("select read");
  id_top_a: assert property (rd && enc == {CSC_ID_OPC1, CSC_ID_CRN, CSC_ID_CRM, CSC_ID_OPC2}
    |=> cp_rdata_o[31:28] == ($past(instruction_not_data_select_o) ? 4'h2 : 4'h7))
    else $error("identification top nibble");
  ctl_fixed_a: assert property (rd && enc == {CSC_CTL_OPC1, CSC_CTL_CRN, CSC_CTL_CRM, CSC_CTL_OPC2}
    |=> (cp_rdata_o & 32'hb510_8000) == 32'h0 && (cp_rdata_o & 32'h00c5_0000) == 32'h00c5_0000)
    else $error("fixed control bits");
  nmsk_ro_a: assert property (cp_req_i && ce_i && cp_write_i
    |=> $stable(nonmaskable_fast_irq_flag_o)) else $error("fast irq flag changed by write");
  endian_copy_a: assert property (exception_entry_i && ce_i
    |=> program_status_endian_o == $past(exception_endianness_o)) else $error("endian copy");
  div_trap_a: assert property (div_valid_i && div_by_zero_i && ce_i
    |=> div_undef_o == $past(divide_zero_trap_enable_o)) else $error("divide trap");
  bg_fault_a: assert property (mem_valid_i && mem_unmapped_i && mpu_enable_i && ce_i
    |=> background_fault_o == !($past(background_region_enable_o) && $past(mem_privileged_i)))
    else $error("background fault");
endmodule // csc_bank_chk

bind csc_bank csc_bank_chk u_chk (.core_clk_i, .reset_n_i, .ce_i, .cp_req_i, .cp_write_i,
  .cp_privileged_i, .cp_opc1_i, .cp_crn_i, .cp_crm_i, .cp_opc2_i, .cp_ack_o, .cp_undef_o,
  .cp_rdata_o, .instruction_not_data_select_o, .nonmaskable_fast_irq_flag_o,
  .exception_endianness_o, .divide_zero_trap_enable_o, .background_region_enable_o,
  .exception_entry_i, .div_valid_i, .div_by_zero_i, .mpu_enable_i, .mem_valid_i,
  .mem_unmapped_i, .mem_privileged_i, .program_status_endian_o, .div_undef_o,
  .background_fault_o);

// ==== bench/csc_core_model.sv ====
// Core-side model issuing coprocessor register accesses.
// Assumes the bank answers one cycle after the request edge.
module csc_core_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        undef_i,
  input  wire logic [31:0] rdata_i,
  output logic             req_o,
  output logic             write_o,
  output logic             priv_o,
  output logic [13:0]      enc_o,
  output logic [31:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // One access: a single request cycle, answer taken the cycle after
  // ==========================================================================
  initial
  begin
    {req_o, write_o, priv_o, enc_o, wdata_o} = '0;
  end

  task automatic xfer(input logic w, input logic p, input logic [13:0] e,
                      input logic [31:0] d, output logic [31:0] rd, output logic u,
                      output logic a);
    @(posedge clk_i);
    #1;
    {req_o, write_o, priv_o, enc_o, wdata_o} = {1'b1, w, p, e, d};
    @(posedge clk_i);
    #1;
    req_o   = 1'b0;
    // Released data no longer shows the last word
    wdata_o = ~d;
    enc_o   = ~e;
    rd      = rdata_i;
    u       = undef_i;
    a       = ack_i;
  endtask
endmodule // csc_core_model

// ==== bench/csc_bank_test.sv ====
// Self-checking bench for the cache-select and system-control bank.
// Assumes the core model in csc_core_model drives every access.
module csc_bank_test
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Signals, model state and tasks
  // ==========================================================================
  localparam logic [13:0] E_SEL = {CSC_SEL_OPC1, CSC_SEL_CRN, CSC_SEL_CRM, CSC_SEL_OPC2};
  localparam logic [13:0] E_ID  = {CSC_ID_OPC1, CSC_ID_CRN, CSC_ID_CRM, CSC_ID_OPC2};
  localparam logic [13:0] E_CTL = {CSC_CTL_OPC1, CSC_CTL_CRN, CSC_CTL_CRM, CSC_CTL_OPC2};
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
  logic cp_req_i, cp_write_i, cp_privileged_i, cp_ack_o, cp_undef_o;
  logic [2:0] cp_opc1_i, cp_opc2_i;
  logic [3:0] cp_crn_i, cp_crm_i;
  logic [31:0] cp_wdata_i, cp_rdata_o, w;
  logic exception_state_reset_input_i, nonmaskable_fast_irq_input_i, endianness_reset_input_i;
  logic instruction_not_data_select_o, exception_state_select_o, nonmaskable_fast_irq_flag_o;
  logic exception_endianness_o, low_latency_select_o, divide_zero_trap_enable_o;
  logic background_region_enable_o, program_status_endian_o, div_undef_o, div_zero_result_o;
  logic background_fault_o, default_map_o, exception_entry_i = 0, div_valid_i = 0;
  logic div_by_zero_i = 0, mpu_enable_i = 0, mem_valid_i = 0, mem_unmapped_i = 0;
  logic mem_privileged_i = 0, m_sel, m_xs, m_nmsk, m_xe, m_ll, m_dt, m_bg;
  logic [15:0] s = 16'hb9e9;
  int n_fail = 0, num_checks = 0, cyc = 0;

  always #4 core_clk_i = ~core_clk_i;

  csc_core_model core (.clk_i(core_clk_i), .ack_i(cp_ack_o), .undef_i(cp_undef_o),
    .rdata_i(cp_rdata_o), .req_o(cp_req_i), .write_o(cp_write_i), .priv_o(cp_privileged_i),
    .enc_o({cp_opc1_i, cp_crn_i, cp_crm_i, cp_opc2_i}), .wdata_o(cp_wdata_i));

  csc_bank dut (.core_clk_i, .reset_n_i, .ce_i, .cp_req_i, .cp_write_i, .cp_privileged_i,
    .cp_opc1_i, .cp_crn_i, .cp_crm_i, .cp_opc2_i, .cp_wdata_i, .cp_ack_o, .cp_undef_o,
    .cp_rdata_o, .exception_state_reset_input_i, .nonmaskable_fast_irq_input_i,
    .endianness_reset_input_i, .instruction_not_data_select_o, .exception_state_select_o,
    .nonmaskable_fast_irq_flag_o, .exception_endianness_o, .low_latency_select_o,
    .divide_zero_trap_enable_o, .background_region_enable_o, .exception_entry_i,
    .div_valid_i, .div_by_zero_i, .mpu_enable_i, .mem_valid_i, .mem_unmapped_i,
    .mem_privileged_i, .program_status_endian_o, .div_undef_o, .div_zero_result_o,
    .background_fault_o, .default_map_o);

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_evt(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t event got %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic rnd(output logic [31:0] v);
    s = lfsr(s);
    v[15:0] = s;
    s = lfsr(s);
    v[31:16] = s;
  endtask

  task automatic acc(input logic wr, input logic p, input logic [13:0] e, input logic [31:0] d,
                     input logic ex_u, input logic [31:0] ex_rd);
    logic [31:0] rd;
    logic        u;
    logic        a;
    core.xfer(wr, p, e, d, rd, u, a);
    chk_reg({30'h0, a, u}, {30'h0, 1'b1, ex_u});
    chk_reg(rd, ex_rd);
  endtask

  task automatic rd_ctl();
    acc(0, 1, E_CTL, 0, 0, 32'h00c5_0000 | {1'b0, m_xs, 2'b0, m_nmsk, 1'b0, m_xe, 3'b0,
      m_ll, 1'b0, m_dt, 1'b0, m_bg, 17'h0});
    chk_reg({exception_state_select_o, nonmaskable_fast_irq_flag_o, exception_endianness_o,
      low_latency_select_o, divide_zero_trap_enable_o, background_region_enable_o,
      instruction_not_data_select_o}, {m_xs, m_nmsk, m_xe, m_ll, m_dt, m_bg, m_sel});
  endtask

  // One event edge; fz holds the clock enable low so nothing may move
  task automatic ev(input logic mpu, input logic pr, input logic um, input logic dz,
                    input logic fz);
    logic [4:0] ex;
    ex = fz ? {m_xe, 4'h0} : {m_xe, dz && m_dt, dz && !m_dt, mpu && um && !(m_bg && pr),
      mpu && um && m_bg && pr};
    @(posedge core_clk_i);
    #1;
    {exception_entry_i, div_valid_i, mem_valid_i, ce_i} = {3'b111, !fz};
    {mpu_enable_i, mem_privileged_i, mem_unmapped_i, div_by_zero_i} = {mpu, pr, um, dz};
    @(posedge core_clk_i);
    #1;
    {exception_entry_i, div_valid_i, mem_valid_i, ce_i} = 4'h1;
    chk_evt({program_status_endian_o, div_undef_o, div_zero_result_o, background_fault_o,
      default_map_o}, ex);
  endtask

  // Reset with new strap values; first access comes after the strap load
  task automatic rst(input logic [2:0] st);
    reset_n_i = 1'b0;
    {endianness_reset_input_i, nonmaskable_fast_irq_input_i, exception_state_reset_input_i} = st;
    {m_xe, m_nmsk, m_xs} = st;
    {m_sel, m_ll, m_dt, m_bg} = '0;
    repeat (2) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    rst(s[2:0]);
    for (int i = 0; i < 10; i++)
    begin
      rd_ctl();
      acc(0, 1, E_SEL, 0, 0, {31'h0, m_sel});
      rnd(w);
      acc(1, 1, E_CTL, w, 0, 0);
      {m_xs, m_xe, m_ll, m_dt, m_bg} = {w[30], w[25], w[21], w[19], w[17]};
      acc(1, 1, E_SEL, ~w, 0, 0);
      m_sel = ~w[0];
      acc(0, 1, E_ID, 0, 0, {m_sel ? CSC_ID_TOP_INSTR : CSC_ID_TOP_DATA, 28'h0});
      ev(w[3], w[4], w[7], w[8], 1'b0);
      acc(w[5], 0, w[6] ? E_SEL : E_CTL, ~w, 1, 0);
    end
    ev(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    rst(s[2:0] | 3'h2);
    rd_ctl();
    acc(1, 1, E_CTL, 0, 0, 0);
    {m_xs, m_xe} = '0;
    acc(1, 1, E_ID, w, 1, 0);
    acc(0, 1, 14'h3fff, 0, 1, 0);
    rd_ctl();
    end_of_test();
  end
endmodule // csc_bank_test
